// ### logic/panel_consts.svh
// constants for the front panel menu and reference selector
`ifndef PANEL_CONSTS_SVH
`define PANEL_CONSTS_SVH
// apb register byte offsets
`define OFS_CTRL      12'h000
`define OFS_GAIN      12'h004
`define OFS_STATUS    12'h008
`define OFS_SAVED     12'h00c
`define OFS_LEVEL     12'h010
// control field positions
`define CTRL_REF_LO   0
`define CTRL_MUTE     2
`define CTRL_REMOTE   3
`define CTRL_IFACE    4
// gain limits in half-dB steps
`define GAIN_MAX      9'd300
`define GAIN_RST      9'd020
// reset defaults of the other settings
`define MODE_RST      2'd2
`define OFFSET_RST    12'h000
`define ADDR_RST      8'h00
// reference level thresholds, signed dBm in detector units
`define LVL_QUAL      8'sd0
`define LVL_FALL      -8'sd1
// timing
`define CLK_HZ        10000000
`define IDLE_SEC      30
`define IDLE_CYC      (`IDLE_SEC * `CLK_HZ)
`define DEB_MS        10
`define DEB_CYC       ((`DEB_MS * `CLK_HZ) / 1000)
`endif

// ### logic/panel_pkg.sv
// types shared by the front panel menu logic
package panel_pkg;
	// menu walk states, one-hot
	typedef enum logic [9:0] {
		ST_NORMAL = 10'b0000000001,
		ST_GAIN   = 10'b0000000010,
		ST_MUTE   = 10'b0000000100,
		ST_REFM   = 10'b0000001000,
		ST_OFFS   = 10'b0000010000,
		ST_REM    = 10'b0000100000,
		ST_IFACE  = 10'b0001000000,
		ST_ADDR   = 10'b0010000000,
		ST_SAVE   = 10'b0100000000,
		ST_SPARE  = 10'b1000000000
	} menu_st_t;
	// reference modes as coded by software
	typedef enum logic [1:0] {
		REF_INT  = 2'd0,
		OUTSIDE_SOURCE_TAG  = 2'd1,
		REF_AUTO = 2'd2
	} ref_mode_t;
	// display tags
	typedef enum logic [1:0] {
		TAG_INT    = 2'd0,
		TAG_EXT    = 2'd1,
		TAG_AUTO_E = 2'd2,
		TAG_AUTO_I = 2'd3
	} ref_tag_t;
	// one full operating configuration
	typedef struct packed {
		logic [8:0]  gain;
		logic        mute;
		logic [1:0]  ref_mode;
		logic [11:0] offset;
		logic        remote;
		logic        iface;
		logic [7:0]  bus_addr;
	} settings_t;
endpackage

// ### logic/panel_menu.sv
// front panel menu controller with reference source selection
//
// Functional notes
// - execute opens every edit session; execute or the idle timeout closes it
// - horizontal switch moves cursor one position
// - vertical switch steps gain digit up/down
// - vertical switch toggles on/off items
// - gain applies live, retained only on yes
// - thirty idle seconds discard edits
// - cursor picks 0.5, 1 or 10 dB step
// - execute advances item; return jumps to save
// - save yes stores edited settings
// - save no restores pre-session settings
// - any loop unlock raises alarm
// - remote led follows remote mode
// - internal mode selects oven oscillator
// - external mode selects outside input
// - auto picks outside while level qualifies
// - auto falls to internal below -1 dBm
// - selected source drives reference output
// - seven items fixed order, then save
// - gain counts half-dB steps, 0 to 300
// - saved settings survive power loss; the bus address keeps only its low six bits
//
// The implementer's own choices: the APB interface to the registers and the address map.
`include "panel_consts.svh"
module panel_menu #(
	parameter int IDLE_CYC = `IDLE_CYC,   // idle timeout in cycles
	parameter int DEB_CYC  = `DEB_CYC,    // debounce settle in cycles
	parameter int PLL_N    = 2            // number of lo loops
) (
	input  wire logic              clk,         // 10 mhz clock
	input  wire logic              rst,         // sync reset, high
	input  wire logic              sw_exec,     // execute switch, high pressed
	input  wire logic              sw_left,     // horizontal left
	input  wire logic              sw_right,    // horizontal right
	input  wire logic              sw_up,       // vertical up
	input  wire logic              sw_down,     // vertical down
	input  wire logic [PLL_N-1:0]  pll_unlock,  // loop unlock flags
	input  wire logic signed [7:0] ext_level,   // outside level, dBm
	input  wire logic              ovenized_oscillator, // internal ref
	input  wire logic              ext_ref_in,  // outside reference
	input  wire logic [31:0]       nv_data,     // retained store readback
	input  wire logic              nv_valid,    // retained store holds data
	output logic                   nv_write,    // retained store write pulse
	output logic [31:0]            nv_wdata,    // retained store data
	output logic                   ref_out,     // reference output
	output logic                   ref_use_ext, // source select
	output panel_pkg::ref_tag_t    ref_tag,     // display tag
	output logic                   alarm,       // alarm condition
	output logic                   remote_led,  // remote indicator
	output logic [8:0]             gain_live,   // gain to converter
	output logic                   mute_live,   // mute to converter
	output panel_pkg::menu_st_t    menu_item,   // shown item
	output logic [1:0]             cursor,      // cursor position
	input  wire logic              psel,        // apb select
	input  wire logic              penable,     // apb enable
	input  wire logic              pwrite,      // apb direction
	input  wire logic [11:0]       paddr,       // apb address
	input  wire logic [31:0]       pwdata,      // apb write data
	output logic [31:0]            prdata,      // apb read data
	output logic                   pready,      // apb ready
	output logic                   pslverr      // apb error
);
	// switch debounce, one lane per switch
	localparam int NSW = 5;
	// lane order exec, left, right, up, down; the hit wires rely on it
	wire  [NSW-1:0] sw_raw = {sw_down, sw_up, sw_right, sw_left, sw_exec};
	wire  [NSW-1:0] sw_stab;     // debounced levels
	logic [NSW-1:0] sw_prev_r;   // previous debounced levels
	wire  [NSW-1:0] sw_hit;      // one-cycle press pulses
	genvar gi;
	generate
		for (gi = 0; gi < NSW; gi++) begin : g_deb
			logic [23:0] cnt_r;   // settle counter, fits 10 ms
			logic        stab_r;  // this lane's debounced level
			// each lane owns its flop; the vector is only a view
			assign sw_stab[gi] = stab_r;
			// a level must hold a full settle time before it counts;
			// a bounce back to the old level restarts the count
			always_ff @(posedge clk) begin
				if (rst) begin
					cnt_r  <= 24'h000000;
					stab_r <= 1'b0;
				end else if (sw_raw[gi] == stab_r) begin
					cnt_r <= 24'h000000;
				end else if (cnt_r >= 24'(DEB_CYC - 1)) begin
					cnt_r  <= 24'h000000;
					stab_r <= sw_raw[gi];
				end else begin
					cnt_r <= cnt_r + 24'h000001;
				end
			end
		end
	endgenerate
	// edge detect the stable levels; history resets to the released
	// level, so leaving reset never looks like a press
	always_ff @(posedge clk) begin
		if (rst) sw_prev_r <= '0;
		else sw_prev_r <= sw_stab;
	end
	// only the press edge acts; a release is ignored
	assign sw_hit = sw_stab & ~sw_prev_r;
	wire hit_exec  = sw_hit[0];
	wire hit_left  = sw_hit[1];
	wire hit_right = sw_hit[2];
	wire hit_up    = sw_hit[3];
	wire hit_down  = sw_hit[4];
	wire hit_vert  = hit_up | hit_down;
	wire any_hit   = |sw_hit;

	// settings: active, retained and pre-session snapshot
	// a power cycle brings back the retained copy; a no answer or an
	// idle timeout brings back the snapshot
	panel_pkg::settings_t act_r, act_nxt;  // active settings
	panel_pkg::settings_t sav_r;           // retained image
	panel_pkg::settings_t snap_r;          // values at session start
	panel_pkg::menu_st_t  st_r, st_nxt;    // menu state
	logic [1:0]  cur_r, cur_nxt;           // cursor, 3 = return mark
	logic        yes_r, yes_nxt;           // save prompt choice
	logic [31:0] idle_r;                   // inactivity counter
	logic        load_r;                   // retained image loaded
	logic        wr_pulse;                 // store request

	wire editing  = (st_r != panel_pkg::ST_NORMAL);
	wire on_ret   = (cur_r == 2'd3);
	// fires on the last quiet cycle, so a session lasts IDLE_CYC cycles
	wire idle_out = editing && (idle_r >= 32'(IDLE_CYC - 1));

	// gain step by cursor digit: halves, units, tens
	// the return mark gives no step, so up/down there is harmless
	logic [8:0] gstep;
	always_comb begin
		case (cur_r)
			2'd0:    gstep = 9'd1;   // 0.5 dB
			2'd1:    gstep = 9'd2;   // 1 dB
			2'd2:    gstep = 9'd20;  // 10 dB
			default: gstep = 9'd0;
		endcase
	end
	// clamp at the ends rather than wrap, so a slip never jumps 150 dB
	wire [9:0] gup = {1'b0, act_r.gain} + {1'b0, gstep};
	wire [8:0] gain_up = (gup > {1'b0, `GAIN_MAX}) ? `GAIN_MAX
		: gup[8:0];
	wire [8:0] gain_dn = (act_r.gain < gstep) ? 9'd0
		: act_r.gain - gstep;

	// apb writes share the active settings with the panel
	// a write lands on the access edge; pready is tied high
	// reads are combinational from the address, with no side effects
	wire apb_wr = psel && penable && pwrite;
	wire wr_ctrl = apb_wr && (paddr == `OFS_CTRL) && !editing;
	wire wr_gain = apb_wr && (paddr == `OFS_GAIN) && !editing;

	// menu walk and edit logic
	// the timeout outranks any switch in the same cycle, so a press on
	// the last quiet cycle does not rescue the session
	always_comb begin
		st_nxt   = st_r;
		act_nxt  = act_r;
		cur_nxt  = cur_r;
		yes_nxt  = yes_r;
		wr_pulse = 1'b0;
		if (idle_out) begin
			act_nxt = snap_r;
			st_nxt  = panel_pkg::ST_NORMAL;
		end else begin
			// cursor moves on every item; return mark at the right end
			if (editing && st_r != panel_pkg::ST_SAVE) begin
				if (hit_left && cur_r != 2'd0) cur_nxt = cur_r - 2'd1;
				if (hit_right && cur_r != 2'd3) cur_nxt = cur_r + 2'd1;
			end
			case (st_r)
				panel_pkg::ST_NORMAL: begin
					// only execute opens a session
					if (hit_exec) begin
						st_nxt  = panel_pkg::ST_GAIN;
						cur_nxt = 2'd0;
					end
					if (wr_ctrl) begin
						act_nxt.ref_mode = pwdata[`CTRL_REF_LO +: 2];
						act_nxt.mute     = pwdata[`CTRL_MUTE];
						act_nxt.remote   = pwdata[`CTRL_REMOTE];
						act_nxt.iface    = pwdata[`CTRL_IFACE];
					end
					if (wr_gain && pwdata[8:0] <= `GAIN_MAX)
						act_nxt.gain = pwdata[8:0];
				end
				panel_pkg::ST_GAIN: begin
					// digit under cursor steps; clamps, never wraps
					if (hit_up && !on_ret) act_nxt.gain = gain_up;
					if (hit_down && !on_ret) act_nxt.gain = gain_dn;
				end
				panel_pkg::ST_MUTE: begin
					if (hit_vert) act_nxt.mute = ~act_r.mute;
				end
				panel_pkg::ST_REFM: begin
					// three-way item: up steps forward, down back
					if (hit_up)
						act_nxt.ref_mode = (act_r.ref_mode == 2'd2) ? 2'd0
							: act_r.ref_mode + 2'd1;
					if (hit_down)
						act_nxt.ref_mode = (act_r.ref_mode == 2'd0) ? 2'd2
							: act_r.ref_mode - 2'd1;
				end
				panel_pkg::ST_OFFS: begin
					// offset and address wrap at field width
					if (hit_up) act_nxt.offset = act_r.offset + 12'h001;
					if (hit_down) act_nxt.offset = act_r.offset - 12'h001;
				end
				panel_pkg::ST_REM: begin
					if (hit_vert) act_nxt.remote = ~act_r.remote;
				end
				panel_pkg::ST_IFACE: begin
					if (hit_vert) act_nxt.iface = ~act_r.iface;
				end
				panel_pkg::ST_ADDR: begin
					if (hit_up) act_nxt.bus_addr = act_r.bus_addr + 8'h01;
					if (hit_down) act_nxt.bus_addr = act_r.bus_addr - 8'h01;
				end
				panel_pkg::ST_SAVE: begin
					// left picks yes, right no; yes preset on entry
					if (hit_left) yes_nxt = 1'b1;
					if (hit_right) yes_nxt = 1'b0;
					// execute on the save prompt closes the session
					if (hit_exec) begin
						st_nxt = panel_pkg::ST_NORMAL;
						if (yes_r) wr_pulse = 1'b1;
						else act_nxt = snap_r;
					end
				end
				default: st_nxt = panel_pkg::ST_NORMAL;
			endcase
			// execute on an item: next item, or save from return mark
			if (hit_exec && editing && st_r != panel_pkg::ST_SAVE) begin
				cur_nxt = 2'd0;
				if (on_ret || st_r == panel_pkg::ST_ADDR) begin
					st_nxt  = panel_pkg::ST_SAVE;
					yes_nxt = 1'b1;
				end else begin
					st_nxt = panel_pkg::menu_st_t'({st_r[8:0], 1'b0});
				end
			end
		end
	end

	// state, cursor, save choice and idle timer
	// 32-bit idle count: thirty seconds at 10 mhz needs 29 bits
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r   <= panel_pkg::ST_NORMAL;
			cur_r  <= 2'd0;
			yes_r  <= 1'b1;
			idle_r <= 32'h00000000;
		end else begin
			st_r   <= st_nxt;
			cur_r  <= cur_nxt;
			yes_r  <= yes_nxt;
			// any switch press restarts the timeout
			idle_r <= (!editing || any_hit) ? 32'h00000000
				: idle_r + 32'h00000001;
		end
	end

	// default settings used until the retained image is read
	// ten dB gain and auto reference when the store is blank
	localparam panel_pkg::settings_t DEF_SET = '{
		gain: `GAIN_RST, mute: 1'b0, ref_mode: `MODE_RST,
		offset: `OFFSET_RST, remote: 1'b0, iface: 1'b0,
		bus_addr: `ADDR_RST};
	// the kept word has 32 bits for 34 bits of settings: the two top
	// bus address bits are dropped, so an address above 63 comes back
	// folded after power loss; every other field returns whole
	panel_pkg::settings_t nv_img;  // kept word unpacked
	assign nv_img = panel_pkg::settings_t'({nv_data[31:6], 2'b00,
		nv_data[5:0]});
	wire [31:0] act_img = {act_nxt[33:8], act_nxt[5:0]};  // word to keep

	// active settings load from retained store once after reset
	// switches cannot act in the load cycle: debounce is longer
	always_ff @(posedge clk) begin
		if (rst) begin
			act_r  <= DEF_SET;
			sav_r  <= DEF_SET;
			snap_r <= DEF_SET;
			load_r <= 1'b0;
		end else if (!load_r) begin
			load_r <= 1'b1;
			if (nv_valid) begin
				act_r <= nv_img;
				sav_r <= nv_img;
			end
		end else begin
			act_r <= act_nxt;
			if (wr_pulse || wr_ctrl || wr_gain) sav_r <= act_nxt;
			// snapshot on entry so a no or timeout can restore
			if (!editing && hit_exec) snap_r <= act_r;
		end
	end

	// retained store write, issued on yes and on apb ctrl and gain writes
	// each request strobes one cycle; an apb write in the cycle right after a yes holds nv_write high for two
	always_ff @(posedge clk) begin
		if (rst) begin
			nv_write <= 1'b0;
			nv_wdata <= 32'h00000000;
		end else begin
			nv_write <= load_r && (wr_pulse || wr_ctrl || wr_gain);
			nv_wdata <= act_img;
		end
	end

	// auto mode source choice with hysteresis
	// between the thresholds the choice holds, so a level hovering
	// near the fall point cannot make the source chatter
	logic auto_ext_r;  // auto mode currently on outside source
	always_ff @(posedge clk) begin
		if (rst) auto_ext_r <= 1'b0;
		else if (ext_level >= `LVL_QUAL) auto_ext_r <= 1'b1;
		else if (ext_level < `LVL_FALL) auto_ext_r <= 1'b0;
	end

	wire sel_ext = (act_r.ref_mode == panel_pkg::OUTSIDE_SOURCE_TAG)
		|| (act_r.ref_mode == panel_pkg::REF_AUTO && auto_ext_r);
	// tag and select are registered; the clock path itself is a mux
	// ref_out is never sampled: the wave passes straight through
	always_ff @(posedge clk) begin
		if (rst) begin
			ref_use_ext <= 1'b0;
			ref_tag     <= panel_pkg::TAG_INT;
			alarm       <= 1'b0;
			remote_led  <= 1'b0;
		end else begin
			ref_use_ext <= sel_ext;
			case (act_r.ref_mode)
				panel_pkg::OUTSIDE_SOURCE_TAG:  ref_tag <= panel_pkg::TAG_EXT;
				panel_pkg::REF_AUTO: ref_tag <= auto_ext_r
					? panel_pkg::TAG_AUTO_E : panel_pkg::TAG_AUTO_I;
				default: ref_tag <= panel_pkg::TAG_INT;
			endcase
			alarm      <= |pll_unlock;
			remote_led <= act_r.remote;
		end
	end
	// TAG_EXT or TAG_AUTO_E is shown when ref_use_ext is high
	assign ref_out = ref_use_ext ? ext_ref_in : ovenized_oscillator;

	assign gain_live = act_r.gain;
	assign mute_live = act_r.mute;
	assign menu_item = st_r;
	assign cursor    = cur_r;

	// apb slave, zero wait; unmapped reads zero with error
	// settings writes are refused while a session is open, so panel
	// and software never edit the same field in one cycle
	wire hit_map = (paddr == `OFS_CTRL) || (paddr == `OFS_GAIN)
		|| (paddr == `OFS_STATUS) || (paddr == `OFS_SAVED)
		|| (paddr == `OFS_LEVEL);
	logic [31:0] rd_mux;
	always_comb begin
		case (paddr)
			`OFS_CTRL:   rd_mux = {27'h0, act_r.iface, act_r.remote,
				act_r.mute, act_r.ref_mode};
			`OFS_GAIN:   rd_mux = {23'h0, act_r.gain};
			`OFS_STATUS: rd_mux = {14'h0, st_r, 1'b0, alarm,
				ref_use_ext, remote_led, ref_tag, cur_r};
			`OFS_SAVED:  rd_mux = {23'h0, sav_r.gain};
			`OFS_LEVEL:  rd_mux = {{24{ext_level[7]}}, ext_level};
			default:     rd_mux = 32'h00000000;
		endcase
	end
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !hit_map;
	assign prdata  = (psel && !pwrite) ? rd_mux : 32'h00000000;
endmodule // panel_menu

// ### test/panel_far_side.sv
// far side model: reference oscillators and retained store
module panel_far_side (
	input  wire logic        clk,                 // bench clock
	input  wire logic        nv_write,            // store strobe
	input  wire logic [31:0] nv_wdata,            // data to keep
	output logic             ovenized_oscillator, // internal ref
	output logic             ext_ref_in,          // outside ref
	output logic [31:0]      nv_data,             // kept data
	output logic             nv_valid             // store holds data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] div_r = 2'h0; // toy divider
	// two unlike waveforms, so a wrong source pick shows at ref_out
	always @(posedge clk) begin
		div_r <= div_r + 2'h1;
	end
	assign ovenized_oscillator = div_r[0];
	assign ext_ref_in = div_r[1];
	// blank at power-up; no reset, contents outlive bench resets
	initial begin
		nv_valid = 1'b0;
		nv_data = 32'h0;
	end
	always @(posedge clk) begin
		if (nv_write === 1'b1) begin
			nv_data <= nv_wdata;
			nv_valid <= 1'b1;
		end
	end
endmodule // panel_far_side

// ### test/panel_menu_sva.sv
// port checker for the front panel menu controller
module panel_menu_sva #(
	parameter int PLL_N = 2 // loop count
) (
	input wire logic                clk,         // clock
	input wire logic                rst,         // reset
	input wire logic [PLL_N-1:0]    pll_unlock,  // unlock flags
	input wire logic signed [7:0]   ext_level,   // outside level
	input wire logic                ovenized_oscillator, // int ref
	input wire logic                ext_ref_in,  // ext ref
	input wire logic                ref_out,     // ref output
	input wire logic                ref_use_ext, // source select
	input wire panel_pkg::ref_tag_t ref_tag,     // display tag
	input wire logic                alarm,       // alarm
	input wire logic [8:0]          gain_live,   // live gain
	input wire logic                nv_write,    // store strobe
	input wire panel_pkg::menu_st_t menu_item,   // shown item
	input wire logic                psel,        // apb select
	input wire logic                penable,     // apb enable
	input wire logic [11:0]         paddr,       // apb address
	input wire logic                pready,      // apb ready
	input wire logic                pslverr      // apb error
);
	// either auto tag shown
	wire is_auto = (ref_tag == panel_pkg::TAG_AUTO_E) ||
		(ref_tag == panel_pkg::TAG_AUTO_I);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_ref_route: assert property (
		ref_out == (ref_use_ext ? ext_ref_in : ovenized_oscillator))
		else $error("reference output not the selected source");
	a_tag_select: assert property (
		ref_use_ext == (ref_tag == panel_pkg::TAG_EXT ||
		ref_tag == panel_pkg::TAG_AUTO_E))
		else $error("tag and source select disagree");
	a_auto_fall: assert property (
		is_auto && ext_level < -8'sd1 |-> ##2
		ref_tag != panel_pkg::TAG_AUTO_E)
		else $error("auto mode kept outside source on low level");
	a_auto_rise: assert property (
		is_auto && ext_level >= 8'sd0 |-> ##2
		ref_tag != panel_pkg::TAG_AUTO_I)
		else $error("auto mode ignored a qualifying level");
	a_auto_hold: assert property (
		ext_level == -8'sd1 ##1 (ext_level == -8'sd1 && is_auto) |=>
		ref_tag == $past(ref_tag) || !is_auto)
		else $error("auto mode toggled inside the hysteresis band");
	a_alarm_set: assert property (
		pll_unlock != '0 |=> alarm)
		else $error("alarm missed a loop unlock");
	a_alarm_clr: assert property (
		pll_unlock == '0 |=> !alarm)
		else $error("alarm raised with all loops locked");
	a_gain_limit: assert property (
		gain_live <= 9'd300)
		else $error("gain beyond full scale");
	a_save_pulse: assert property (
		nv_write |=> !nv_write)
		else $error("store strobe longer than one cycle");
	a_menu_open: assert property (
		menu_item == panel_pkg::ST_NORMAL ##1
		menu_item != panel_pkg::ST_NORMAL |-> menu_item == panel_pkg::ST_GAIN)
		else $error("session opened somewhere other than gain");
	a_menu_hot: assert property (
		$onehot(menu_item))
		else $error("menu state not one-hot");
	a_bad_addr: assert property (
		psel && penable && paddr > 12'h010 |-> pslverr && pready)
		else $error("unmapped access not flagged");
endmodule // panel_menu_sva

bind panel_menu panel_menu_sva #(.PLL_N(PLL_N)) i_panel_menu_sva (
	.clk(clk), .rst(rst), .pll_unlock(pll_unlock), .ext_level(ext_level),
	.ovenized_oscillator(ovenized_oscillator), .ext_ref_in(ext_ref_in),
	.ref_out(ref_out), .ref_use_ext(ref_use_ext), .ref_tag(ref_tag),
	.alarm(alarm), .gain_live(gain_live), .nv_write(nv_write),
	.menu_item(menu_item), .psel(psel), .penable(penable),
	.paddr(paddr), .pready(pready), .pslverr(pslverr));

// ### test/front_panel_menu_ref_select_tb_top.sv
// self-checking bench for the front panel menu controller
`include "panel_consts.svh"
module front_panel_menu_ref_select_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int IDLE = 200; // shortened idle timeout
	logic              clk = 1'b0;       // 10 mhz
	logic              rst = 1'b1;       // sync reset
	logic [4:0]        sw_vec = 5'h00;   // exec left right up down
	logic [1:0]        pll_unlock = 2'h0; // loop flags
	logic signed [7:0] ext_level = 8'sh00; // outside level
	logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0]       paddr = 12'h000;  // apb address
	logic [31:0]       pwdata = 32'h0, prdata, nv_data, nv_wdata, rd;
	logic              nv_write, nv_valid, ovenized_oscillator, er;
	logic              ext_ref_in, ref_out, ref_use_ext, alarm;
	logic              remote_led, mute_live, pready, pslverr;
	logic [8:0]        gain_live;        // live gain
	logic [1:0]        cursor;           // cursor position
	panel_pkg::ref_tag_t ref_tag;        // display tag
	panel_pkg::menu_st_t menu_item;      // shown item
	int miscompares = 0;
	int samples_checked = 0;
	int key_q[8] = '{3, 2, 3, 2, 3, 4, 1, 4}; // switch index
	int gain_q[8] = '{21, 21, 23, 23, 43, 23, 23, 21};
	int cur_q[8] = '{0, 1, 1, 2, 2, 2, 1, 1};
	int lv_q[6] = '{-1, -2, -1, 0, -2, 3}; // level walk
	int tag_q[6] = '{2, 3, 3, 2, 3, 2};
	panel_menu #(.IDLE_CYC(IDLE), .DEB_CYC(2)) i_panel_menu (
		.clk(clk), .rst(rst), .sw_exec(sw_vec[0]), .sw_left(sw_vec[1]),
		.sw_right(sw_vec[2]), .sw_up(sw_vec[3]), .sw_down(sw_vec[4]),
		.pll_unlock(pll_unlock), .ext_level(ext_level),
		.ovenized_oscillator(ovenized_oscillator), .ext_ref_in(ext_ref_in),
		.nv_data(nv_data), .nv_valid(nv_valid), .nv_write(nv_write),
		.nv_wdata(nv_wdata), .ref_out(ref_out), .ref_use_ext(ref_use_ext),
		.ref_tag(ref_tag), .alarm(alarm), .remote_led(remote_led),
		.gain_live(gain_live), .mute_live(mute_live), .menu_item(menu_item),
		.cursor(cursor), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	panel_far_side i_panel_far_side (.clk(clk), .nv_write(nv_write),
		.nv_wdata(nv_wdata), .ovenized_oscillator(ovenized_oscillator),
		.ext_ref_in(ext_ref_in), .nv_data(nv_data), .nv_valid(nv_valid));
	// free running clock
	initial begin
		forever #50 clk = ~clk;
	end
	// compare and count
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one apb transfer; read data taken where pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// access holds until pready is seen at a rising edge
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			miscompares++; // no answer is a failure
			$display("Error pready expected 1 seen %b", pready);
		end
	endtask
	// hold a switch long past debounce, then release just as long
	task automatic press(input int k);
		@(posedge clk);
		sw_vec[k] <= 1'b1;
		repeat (8) @(posedge clk);
		sw_vec[k] <= 1'b0;
		repeat (8) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask
	// verdict, shared by the main sequence and the watchdog
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// hang guard, over twenty times the expected run
	initial begin
		#2000000;
		miscompares++;
		$display("Error watchdog expected end seen hang");
		wrap_up();
	end
	// main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		wait_n(3);
		check("gain_live", 32'd20, gain_live);
		check("ref_tag", panel_pkg::TAG_AUTO_E, ref_tag);
		apb(1'b0, `OFS_CTRL, 32'h0);
		check("ctrl mode", 32'h2, 32'(rd[1:0]));
		apb(1'b0, 12'h020, 32'h0);
		check("unmapped err", 32'h1, 32'(er));
		check("unmapped data", 32'h0, rd);
		$display("test reset_and_bus done");
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, `OFS_CTRL, 32'(i));
			wait_n(2);
			check("ref_tag", 32'(i), ref_tag);
			check("ref_use_ext", 32'(i), ref_use_ext);
			check("ref_out", i ? ext_ref_in : ovenized_oscillator, ref_out);
		end
		apb(1'b1, `OFS_CTRL, 32'h0000000a);
		wait_n(2);
		check("remote_led", 32'h1, remote_led);
		apb(1'b1, `OFS_CTRL, 32'h00000002);
		wait_n(2);
		check("remote_led", 32'h0, remote_led);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			ext_level <= 8'(lv_q[i]);
			wait_n(3);
			check("auto tag", 32'(tag_q[i]), ref_tag);
		end
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			pll_unlock <= 2'(1 << i);
			wait_n(2);
			check("alarm", 32'h1, alarm);
			@(posedge clk);
			pll_unlock <= 2'h0;
			wait_n(2);
			check("alarm", 32'h0, alarm);
		end
		$display("test reference_and_alarm done");
		press(3);
		check("gain no session", 32'd20, gain_live);
		press(0);
		check("menu", panel_pkg::ST_GAIN, menu_item);
		for (int i = 0; i < 8; i++) begin
			press(key_q[i]);
			check("gain", 32'(gain_q[i]), gain_live);
			check("cursor", 32'(cur_q[i]), cursor);
		end
		press(0);
		check("menu", panel_pkg::ST_MUTE, menu_item);
		press(3);
		check("mute up", 32'h1, mute_live);
		press(4);
		check("mute down", 32'h0, mute_live);
		for (int i = 3; i < 9; i++) begin
			press(0);
			check("menu walk", 32'h1 << i, menu_item);
		end
		press(2);
		press(0);
		check("menu", panel_pkg::ST_NORMAL, menu_item);
		check("gain reverted", 32'd20, gain_live);
		$display("test edit_and_discard done");
		press(0);
		press(3);
		for (int i = 0; i < 3; i++) press(2);
		press(0);
		check("menu", panel_pkg::ST_SAVE, menu_item);
		press(0);
		check("gain kept", 32'd21, gain_live);
		apb(1'b0, `OFS_SAVED, 32'h0);
		check("saved gain", 32'd21, 32'(rd[8:0]));
		press(0);
		press(3);
		check("gain live", 32'd22, gain_live);
		wait_n(IDLE + 20);
		check("menu", panel_pkg::ST_NORMAL, menu_item);
		check("gain idle", 32'd21, gain_live);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		wait_n(3);
		check("gain restored", 32'd21, gain_live);
		$display("test save_timeout_power done");
		apb(1'b1, `OFS_GAIN, 32'd301);
		apb(1'b0, `OFS_GAIN, 32'h0);
		check("gain over", 32'd21, 32'(rd[8:0]));
		apb(1'b1, `OFS_GAIN, 32'd300);
		wait_n(2);
		check("gain top", 32'd300, gain_live);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		wait_n(3);
		check("gain top kept", 32'd300, gain_live);
		press(0);
		apb(1'b1, `OFS_GAIN, 32'd5);
		press(3);
		check("gain clamp", 32'd300, gain_live);
		$display("test gain_limits done");
		wrap_up();
	end
endmodule // front_panel_menu_ref_select_tb_top
